// ==== adc_seq_pkg.sv ====
package adc_seq_pkg;

    // ------------------------------------------------------------
    // conversion timing, in clock periods
    // ------------------------------------------------------------
    localparam int          CLOCK_PERIOD_NS     = 10;
    localparam int          TIMER_WIDTH         = 13;
    localparam logic [12:0] OFFSET_CHARGE_COUNT = 13'd4000;
    localparam logic [12:0] COMP_OFFSET_LIMIT   = 13'd800;
    localparam logic [12:0] RAMP_UP_COUNT       = 13'd4000;
    localparam logic [12:0] MEASURE_COUNT       = 13'd4000;

    // ------------------------------------------------------------
    // result coding
    // ------------------------------------------------------------
    localparam logic [11:0] FULL_SCALE          = 12'd1999;
    localparam logic [11:0] OVERRANGE_VALUE     = 12'd2000;
    localparam logic [11:0] UNDERRANGE_LIMIT    = 12'd180;
    localparam logic [11:0] HALF_DIGIT_WEIGHT   = 12'd1000;

    // ------------------------------------------------------------
    // display multiplexing
    // ------------------------------------------------------------
    localparam logic [6:0]  MUX_PERIOD          = 7'd80;
    localparam logic [6:0]  DIGIT_SLOT          = 7'd20;
    localparam logic [6:0]  BLANK_COUNT         = 7'd2;

    // ------------------------------------------------------------
    // register map (byte offsets) and fields
    // ------------------------------------------------------------
    localparam logic [7:0]  CONTROL_OFFSET      = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET       = 8'h04;
    localparam logic [7:0]  RESULT_OFFSET       = 8'h08;
    localparam logic [7:0]  ZERO_OFFSET         = 8'h0c;
    localparam int          CTRL_RUN_BIT        = 0;
    localparam int          CTRL_UPDATE_BIT     = 1;
    localparam logic [1:0]  CONTROL_RESET       = 2'h1;
    localparam int          STAT_SEG_LSB        = 0;
    localparam int          STAT_POL_BIT        = 4;
    localparam int          STAT_OVER_BIT       = 5;
    localparam int          STAT_UNDER_BIT      = 6;
    localparam int          STAT_ARMED_BIT      = 7;

    // conversion segments in their fixed order
    typedef enum logic [2:0] {
        SEG_OFFSET_CHARGE,
        SEG_COMP_OFFSET,
        SEG_OFFSET_RECHARGE,
        SEG_RAMP_UP,
        SEG_RAMP_DOWN_ZERO,
        SEG_MEASURE
    } segment_type;

endpackage

// ==== result_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// latched result handed from the sequencer to the digit scanner
interface result_link_if;
    logic [11:0] count;
    logic        positive;
    logic        overrange;
    logic        underrange;
    logic        restart;

    modport source (output count, output positive, output overrange,
                    output underrange, output restart);
    modport sink   (input count, input positive, input overrange,
                    input underrange, input restart);
endinterface

`default_nettype wire

// ==== cycle_counter.sv ====
`timescale 1ns/1ps
`default_nettype none

// free counter with synchronous clear, frozen while ce is low
module cycle_counter #(
    parameter int WIDTH = 13
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] count
);

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count <= '0;
        end else if (ce) begin
            count <= clear ? '0 : count + 1'b1;
        end
    end

endmodule

`default_nettype wire

// ==== digit_scanner.sv ====
`timescale 1ns/1ps
`default_nettype none

module digit_scanner
    import adc_seq_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    result_link_if.sink     link,
    output logic            digit_select_half,
    output logic            digit_select_hundreds,
    output logic            digit_select_tens,
    output logic            digit_select_units,
    output logic      [3:0] bcd_data
);

    logic [6:0]  scan;
    logic [1:0]  slot;
    logic        lit;
    logic        half_one;
    logic [3:0]  hundreds;
    logic [3:0]  tens;
    logic [3:0]  units;
    logic [11:0] low_part;
    logic [3:0]  msd_code;
    logic [3:0]  next_bcd;

    // ------------------------------------------------------------
    // scan position: four slots of 20 clocks, first two blanked
    // ------------------------------------------------------------
    assign slot     = 2'(scan / DIGIT_SLOT);
    assign lit      = (scan % DIGIT_SLOT) >= BLANK_COUNT; // see RQ18

    // ------------------------------------------------------------
    // decimal split of the latched count
    // ------------------------------------------------------------
    assign half_one = link.count >= HALF_DIGIT_WEIGHT;
    assign low_part = half_one ? 12'(link.count - HALF_DIGIT_WEIGHT) : link.count;
    assign hundreds = 4'(low_part / 12'd100);
    assign tens     = 4'((low_part / 12'd10) % 12'd10);
    assign units    = 4'(low_part % 12'd10);

    // most significant digit: half digit, polarity, range flags
    assign msd_code[3] = !(half_one || link.overrange);       // see RQ12
    assign msd_code[2] = link.positive;                        // see RQ13
    assign msd_code[1] = !half_one || link.overrange || link.underrange; // see RQ15
    assign msd_code[0] = link.overrange || link.underrange;    // see RQ14

    assign next_bcd = (slot == 2'd0) ? msd_code :
                      (slot == 2'd1) ? hundreds :
                      (slot == 2'd2) ? tens : units;

    // ------------------------------------------------------------
    // scan counter, restarted by end of conversion
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            scan <= 7'h00;
        end else if (ce) begin
            if (link.restart || scan == MUX_PERIOD - 7'd1) begin // see RQ18
                scan <= 7'h00;
            end else begin
                scan <= scan + 7'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // registered selects and bcd data
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            digit_select_half     <= 1'b0;
            digit_select_hundreds <= 1'b0;
            digit_select_tens     <= 1'b0;
            digit_select_units    <= 1'b0;
            bcd_data              <= 4'h0;
        end else if (ce) begin
            digit_select_half     <= lit && slot == 2'd0; // see RQ18
            digit_select_hundreds <= lit && slot == 2'd1;
            digit_select_tens     <= lit && slot == 2'd2;
            digit_select_units    <= lit && slot == 2'd3;
            bcd_data              <= next_bcd;
        end
    end

endmodule

`default_nettype wire

// ==== dual_slope_adc_sequencer.sv ====
// Functional notes
// RQ1: six segments in fixed order, repeated for either polarity.
// RQ2: segment one shorts the integrator, charges offset capacitor, 4000 clocks.
// RQ3: segment two ends at comparator threshold, under 800 clocks.
// RQ4: segment two clock count is stored as comparator offset.
// RQ5: segment three repeats segment one, 4000 clocks.
// RQ6: segment four integrates input; switches follow previous polarity.
// RQ7: segment five ramps down on reference for the stored offset count.
// RQ8: segment six continues ramp-down 4000 clocks; result is counted there.
// RQ9: result is input over reference, ratio one giving 1999.
// RQ10: count above 1999 shows overrange: msd bit3 low, bit0 high.
// RQ11: count below 180 shows underrange: msd bit0 high, bit3 high.
// RQ12: msd bit3 is half digit, low for one, high for zero.
// RQ13: msd bit2 is polarity, high positive, low negative.
// RQ14: msd bit0 high flags out of range; bit3 tells which kind.
// RQ15: msd codes 1110,1010,1111,1011,0100,0000,0111,0011.
// RQ16: an external full-digit decoder blanks codes 1010 through 1111.
// RQ17: end of each conversion gives a half clock period pulse.
// RQ18: digit selects scan msd to lsd after end pulse, 2-clock blanking, clock/80.
// RQ19: results latch only if update rising edge came before ramp-down; an APB write with the update bit set also arms the latch.
// RQ20: segments advance on count expiry or comparator trip; trip captures result.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dual_slope_adc_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog front end
    input  wire logic        comparator_in,
    input  wire logic        polarity_in,
    output logic             integrator_short,
    output logic             offset_charge,
    output logic             input_connect,
    output logic             reference_connect,
    output logic             input_invert,
    // display side
    input  wire logic        display_update_in,
    output logic             conversion_done_pulse,
    output logic             digit_select_half,
    output logic             digit_select_hundreds,
    output logic             digit_select_tens,
    output logic             digit_select_units,
    output logic      [3:0]  bcd_data
);

    segment_type  segment;
    segment_type  next_segment;
    logic [12:0]  timer;
    logic         timer_clear;
    logic [2:0]   sync_a;
    logic [2:0]   sync_b;
    logic [2:0]   sync_c;
    logic [2:0]   pin_level;
    logic         comp_trip;
    logic         pol_level;
    logic         update_level;
    logic         update_prev;
    logic         update_rise;
    logic [1:0]   control;
    logic         run;
    logic [9:0]   zero_count;
    logic         last_positive;
    logic         armed;
    logic         done;
    logic [11:0]  raw_count;
    logic         raw_over;
    logic [11:0]  shown_count;
    logic         shown_positive;
    logic         shown_over;
    logic         eoc;
    logic         apb_access;
    logic         apb_write;
    logic         sw_update;
    logic         addr_hit;
    logic [31:0]  status_word;
    logic [31:0]  next_prdata;
    logic [12:0]  zero_len;
    logic         seg_expired;

    result_link_if link ();

    // ------------------------------------------------------------
    // pin synchronisers: three stages, accepted when stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync_a    <= 3'h0;
            sync_b    <= 3'h0;
            sync_c    <= 3'h0;
            pin_level <= 3'h0;
        end else if (ce) begin
            sync_a    <= {display_update_in, polarity_in, comparator_in};
            sync_b    <= sync_a;
            sync_c    <= sync_b;
            pin_level <= (pin_level & (sync_b ^ sync_c)) | (sync_c & ~(sync_b ^ sync_c));
        end
    end

    assign comp_trip    = pin_level[0];
    assign pol_level    = pin_level[1];
    assign update_level = pin_level[2];
    assign update_rise  = update_level && !update_prev;

    // ------------------------------------------------------------
    // segment timer
    // ------------------------------------------------------------
    cycle_counter #(
        .WIDTH (TIMER_WIDTH)
    ) segment_timer (
        .clock   (clock),
        .sys_rst (sys_rst),
        .ce      (ce),
        .clear   (timer_clear),
        .count   (timer)
    );

    // ------------------------------------------------------------
    // segment sequencing
    // ------------------------------------------------------------
    assign run      = control[CTRL_RUN_BIT];
    assign zero_len = {3'b000, zero_count};
    assign done     = segment == SEG_MEASURE
                      && (comp_trip || timer == MEASURE_COUNT - 13'd1); // see RQ20

    always_comb begin
        next_segment = segment;
        seg_expired  = 1'b0;
        unique case (segment)
            SEG_OFFSET_CHARGE, SEG_OFFSET_RECHARGE: begin
                seg_expired = timer == OFFSET_CHARGE_COUNT - 13'd1; // see RQ2 see RQ5
            end
            SEG_COMP_OFFSET: begin
                seg_expired = comp_trip || timer == COMP_OFFSET_LIMIT - 13'd1; // see RQ3
            end
            SEG_RAMP_UP: begin
                seg_expired = timer == RAMP_UP_COUNT - 13'd1;
            end
            SEG_RAMP_DOWN_ZERO: begin
                seg_expired = 13'(timer + 13'd1) >= zero_len; // see RQ7
            end
            SEG_MEASURE: begin
                seg_expired = done; // see RQ8
            end
        endcase
        if (seg_expired) begin
            unique case (segment) // see RQ1
                SEG_OFFSET_CHARGE:   next_segment = SEG_COMP_OFFSET;
                SEG_COMP_OFFSET:     next_segment = SEG_OFFSET_RECHARGE;
                SEG_OFFSET_RECHARGE: next_segment = SEG_RAMP_UP;
                SEG_RAMP_UP:         next_segment = SEG_RAMP_DOWN_ZERO;
                SEG_RAMP_DOWN_ZERO:  next_segment = SEG_MEASURE;
                SEG_MEASURE:         next_segment = SEG_OFFSET_CHARGE;
            endcase
        end
        if (!run) begin
            next_segment = SEG_OFFSET_CHARGE;
        end
    end

    assign timer_clear = !run || seg_expired;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            segment <= SEG_OFFSET_CHARGE;
        end else if (ce) begin
            segment <= next_segment;
        end
    end

    // ------------------------------------------------------------
    // offset, polarity and result capture
    // ------------------------------------------------------------
    assign raw_count = comp_trip ? 12'(timer >> 1) : OVERRANGE_VALUE; // see RQ9
    assign raw_over  = raw_count > FULL_SCALE;                        // see RQ10

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            zero_count    <= 10'h000;
            last_positive <= 1'b1;
        end else if (ce) begin
            if (segment == SEG_COMP_OFFSET && seg_expired) begin
                zero_count <= 10'(timer); // see RQ4
            end
            if (segment == SEG_RAMP_UP && seg_expired) begin
                last_positive <= pol_level;
            end
        end
    end

    // switch settings decoded from the segment register, input inversion from the latched polarity
    assign integrator_short  = run && (segment == SEG_OFFSET_CHARGE
                                       || segment == SEG_OFFSET_RECHARGE); // see RQ2
    assign offset_charge     = integrator_short; // see RQ5
    assign input_connect     = run && segment == SEG_RAMP_UP;
    assign input_invert      = !last_positive;   // see RQ6
    assign reference_connect = run && (segment == SEG_RAMP_DOWN_ZERO
                                       || segment == SEG_MEASURE);

    // ------------------------------------------------------------
    // display update arming and output latches
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            update_prev <= 1'b0;
            armed       <= 1'b0;
        end else if (ce) begin
            update_prev <= update_level;
            if ((update_rise || sw_update) && segment <= SEG_RAMP_UP) begin
                armed <= 1'b1; // see RQ19
            end else if (done) begin
                armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shown_count    <= 12'h000;
            shown_positive <= 1'b1;
            shown_over     <= 1'b0;
            eoc            <= 1'b0;
        end else if (ce) begin
            eoc <= done;
            if (done && armed) begin // see RQ19
                shown_count    <= raw_count;
                shown_positive <= last_positive;
                shown_over     <= raw_over;
            end
        end
    end

    // end pulse spans the first half of the clock period
    assign conversion_done_pulse = eoc && clock; // see RQ17

    assign link.count      = shown_count;
    assign link.positive   = shown_positive;
    assign link.overrange  = shown_over;
    assign link.underrange = shown_count < UNDERRANGE_LIMIT; // see RQ11
    assign link.restart    = eoc;

    digit_scanner scanner (
        .clock                 (clock),
        .sys_rst               (sys_rst),
        .ce                    (ce),
        .link                  (link.sink),
        .digit_select_half     (digit_select_half),
        .digit_select_hundreds (digit_select_hundreds),
        .digit_select_tens     (digit_select_tens),
        .digit_select_units    (digit_select_units),
        .bcd_data              (bcd_data)
    );

    // ------------------------------------------------------------
    // apb register slave, zero wait states
    // ------------------------------------------------------------
    assign apb_access = psel && penable;
    assign apb_write  = apb_access && pwrite && paddr == CONTROL_OFFSET;
    assign sw_update  = apb_write && pwdata[CTRL_UPDATE_BIT];
    assign addr_hit   = paddr == CONTROL_OFFSET || paddr == STATUS_OFFSET
                        || paddr == RESULT_OFFSET || paddr == ZERO_OFFSET;
    assign pready     = 1'b1;
    assign pslverr    = apb_access && !addr_hit;

    assign status_word = {24'h0, armed, link.underrange, shown_over,
                          shown_positive, 1'b0, segment};

    assign next_prdata = (paddr == CONTROL_OFFSET) ? {31'h0, control[CTRL_RUN_BIT]} :
                         (paddr == STATUS_OFFSET)  ? status_word :
                         (paddr == RESULT_OFFSET)  ? {20'h0, shown_count} :
                         (paddr == ZERO_OFFSET)    ? {22'h0, zero_count} :
                                                     32'h00000000;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            control <= CONTROL_RESET;
            prdata  <= 32'h00000000;
        end else if (ce) begin
            if (apb_write) begin
                control <= {1'b0, pwdata[CTRL_RUN_BIT]};
            end
            if (psel && !penable && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

endmodule

`default_nettype wire

// ==== adc_seq_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker
    import adc_seq_pkg::*;
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        integrator_short,
    input wire logic        input_connect,
    input wire logic        reference_connect,
    input wire logic        conversion_done_pulse,
    input wire logic        digit_select_half,
    input wire logic        digit_select_hundreds,
    input wire logic        digit_select_tens,
    input wire logic        digit_select_units,
    input wire logic [3:0]  bcd_data
);
    // ------------------------------------------------------------
    // helpers, sampled on the falling edge
    // ------------------------------------------------------------
    default clocking cb @(negedge clock);
    endclocking
    default disable iff (sys_rst);
    logic [12:0] charge_cnt;
    // any digit on; software stop
    wire any_sel = digit_select_half | digit_select_hundreds | digit_select_tens
                   | digit_select_units;
    wire stop_wr = psel & penable & pwrite & (paddr == CONTROL_OFFSET) & ~pwdata[CTRL_RUN_BIT];
    // charge segment length
    always_ff @(negedge clock) begin
        charge_cnt <= (sys_rst | ~integrator_short) ? 13'h0000 : charge_cnt + 13'h0001;
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_charge_length: assert property ($fell(integrator_short) && !$past(stop_wr)
        && !$past(stop_wr, 2) |-> charge_cnt == OFFSET_CHARGE_COUNT) else $error("charge length");
    a_ref_after_ramp: assert property ($rose(reference_connect) |-> $past(input_connect))
        else $error("ramp down not after ramp up");
    a_wrap_to_charge: assert property ($fell(reference_connect)
        |-> integrator_short && conversion_done_pulse) else $error("no wrap at end");
    a_done_single: assert property (conversion_done_pulse |=> !conversion_done_pulse)
        else $error("done pulse too long");
    a_msd_first: assert property ($rose(conversion_done_pulse)
        |-> ##[1:6] digit_select_half) else $error("msd not first");
    a_blank_gap: assert property ($fell(any_sel) |-> !any_sel [*2])
        else $error("blanking gap short");
    a_select_one_hot: assert property ($onehot0({digit_select_half, digit_select_hundreds,
        digit_select_tens, digit_select_units})) else $error("two digits on");
    a_msd_code: assert property (digit_select_half |-> bcd_data inside
        {4'he, 4'ha, 4'hf, 4'hb, 4'h4, 4'h0, 4'h7, 4'h3}) else $error("bad msd code");
    c_done: cover property (conversion_done_pulse);
    c_out_of_range: cover property (digit_select_half && bcd_data[0]);
    c_stop: cover property (stop_wr);
endmodule
bind dual_slope_adc_sequencer adc_seq_checker u_adc_seq_checker (
    .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .integrator_short,
    .input_connect, .reference_connect, .conversion_done_pulse, .digit_select_half,
    .digit_select_hundreds, .digit_select_tens, .digit_select_units, .bcd_data
);
`default_nettype wire

// ==== display_decoder_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module display_decoder_model (
    input wire logic       digit_select_half,
    input wire logic [3:0] bcd_data,
    output logic           msd_blank
);
    // full-digit decoder on the msd blanks every non-decimal code
    assign msd_blank = digit_select_half & (bcd_data > 4'h9);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import adc_seq_pkg::*;
;
    logic        clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q;
    logic        comparator_in = 1'b0, polarity_in = 1'b1, display_update_in = 1'b0, e;
    wire  [31:0] prdata;
    wire  [3:0]  bcd_data;
    wire         pready, pslverr, integrator_short, offset_charge, input_connect, input_invert;
    wire         reference_connect, conversion_done_pulse, msd_blank, digit_select_half;
    wire         digit_select_hundreds, digit_select_tens, digit_select_units;
    int          err_total = 0, num_checks = 0;
    dual_slope_adc_sequencer u_dual_slope_adc_sequencer (
        .clock, .sys_rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .comparator_in, .polarity_in, .integrator_short, .offset_charge,
        .input_connect, .reference_connect, .input_invert, .display_update_in,
        .conversion_done_pulse, .digit_select_half, .digit_select_hundreds,
        .digit_select_tens, .digit_select_units, .bcd_data
    );
    display_decoder_model u_display_decoder_model (.digit_select_half, .bcd_data, .msd_blank);
    // 100 MHz clock
    always #5 clock = ~clock;
    // ------------------------------------------------------------
    // bus cycle and comparisons
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input string n, input logic [31:0] x, input logic [31:0] s);
        num_checks++;
        if (s !== x) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    // filter-delayed counts, margin three
    task automatic near(input string n, input logic [31:0] x, input logic [31:0] s);
        num_checks++;
        if ((^s === 1'bx) || (s > x + 32'h3) || (s + 32'h3 < x)) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    // comparator trips d2 into segment two, d6 into ramp down (0: never)
    task automatic convert(input int d2, input int d6, input logic p, input logic u, input logic v);
        polarity_in <= p;
        @(negedge integrator_short);
        repeat (d2) @(posedge clock);
        comparator_in <= 1'b1;
        @(posedge integrator_short);
        @(posedge clock);
        comparator_in <= 1'b0;
        @(posedge input_connect);
        @(posedge clock);
        check("invert", {31'h0, v}, {31'h0, input_invert});
        display_update_in <= u;
        repeat (8) @(posedge clock);
        display_update_in <= 1'b0;
        @(posedge reference_connect);
        if (d6 > 0) begin
            repeat (d6) @(posedge clock);
            comparator_in <= 1'b1;
        end
        @(posedge conversion_done_pulse);
        @(posedge clock);
        comparator_in <= 1'b0;
    endtask
    task automatic msd(input logic [3:0] x);
        @(posedge digit_select_half);
        @(negedge clock);
        check("msd", {28'h0, x}, {28'h0, bcd_data});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_apb();
        apb(1'b0, CONTROL_OFFSET, 32'h0);
        check("control", 32'h1, q);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped", 32'h1, {31'h0, e});
        apb(1'b1, CONTROL_OFFSET, 32'h0);
        repeat (3) @(posedge clock);
        check("stopped", 32'h0, {28'h0, integrator_short, offset_charge, input_connect,
            reference_connect});
        apb(1'b1, CONTROL_OFFSET, 32'h1);
        $display("test apb done");
    endtask
    task automatic t_full();
        convert(100, 3100, 1'b1, 1'b1, 1'b0);
        msd(4'h4);
        apb(1'b0, ZERO_OFFSET, 32'h0);
        near("offset", 32'h67, {22'h0, q[9:0]});
        apb(1'b0, RESULT_OFFSET, 32'h0);
        near("result", 32'h5dc, {20'h0, q[11:0]});
        $display("test full done");
    endtask
    task automatic t_over();
        convert(100, 0, 1'b0, 1'b1, 1'b0);
        msd(4'h3);
        apb(1'b0, RESULT_OFFSET, 32'h0);
        check("result", {20'h0, OVERRANGE_VALUE}, {20'h0, q[11:0]});
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check("over", 32'h1, {31'h0, q[STAT_OVER_BIT]});
        $display("test over done");
    endtask
    task automatic t_under();
        convert(100, 300, 1'b1, 1'b1, 1'b1);
        msd(4'hf);
        check("blank", 32'h1, {31'h0, msd_blank});
        apb(1'b0, RESULT_OFFSET, 32'h0);
        near("result", 32'h64, {20'h0, q[11:0]});
        $display("test under done");
    endtask
    task automatic t_hold();
        convert(100, 1100, 1'b1, 1'b0, 1'b0);
        apb(1'b0, RESULT_OFFSET, 32'h0);
        near("held", 32'h64, {20'h0, q[11:0]});
        msd(4'hf);
        $display("test hold done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog, about five conversions
    initial begin
        repeat (80000) @(posedge clock);
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        t_apb();
        t_full();
        t_over();
        t_under();
        t_hold();
        print_verdict();
    end
endmodule
`default_nettype wire
